//--- nmfd_pkg.sv
package nmfd_pkg;
	// ****************************************************************
	// message layout (position p of m1..m276 sits at index MSG_LEN-p)
	// ****************************************************************
	localparam int MSG_LEN = 276;
	localparam int POS_TYPE = 15;
	localparam int W_TYPE = 6;
	localparam logic [5:0] MT_DIFF_A = 6'h22;
	localparam logic [5:0] MT_DIFF_B = 6'h0D;
	localparam logic [5:0] MT_DIFF_C = 6'h0E;
	localparam logic [5:0] MT_OFFSET = 6'h23;
	localparam logic [5:0] MT_TEXT_A = 6'h24;
	localparam logic [5:0] MT_TEXT_B = 6'h0F;
	// time-offset message fields
	localparam int POS_SYS = 155;
	localparam int W_SYS = 3;
	localparam logic [2:0] SYS_NONE = 3'h0;
	localparam logic [2:0] SYS_FOREIGN_A = 3'h1;
	localparam logic [2:0] SYS_FOREIGN_B = 3'h2;
	localparam int POS_CLK = 39;
	localparam int W_CLK = 89;
	localparam int POS_TOW = 158;
	localparam int W_TOW = 16;
	localparam int TOW_SHIFT = 4;
	localparam int W_TOW_S = 20;
	localparam int POS_WEEK = 174;
	localparam int W_WEEK = 13;
	localparam int POS_BIAS = 187;
	localparam int W_BIAS = 16;
	localparam int POS_DRIFT = 203;
	localparam int W_DRIFT = 13;
	localparam int POS_DRATE = 216;
	localparam int W_DRATE = 7;
	localparam int W_COEF = 32;
	localparam int SEC_PER_WEEK = 604800;
	// range accuracy indices
	localparam int POS_REF_IDX = 100;
	localparam int POS_RATE_IDX = 105;
	localparam int W_IDX = 5;
	localparam int W_IDX_EXT = 8;
	localparam logic [4:0] IDX_UNPRED = 5'h10;
	localparam logic [4:0] IDX_BEST = 5'h11;
	// reference accuracy upper bound in cm, by index+16
	localparam logic [20:0] REF_CM_TBL [32] = '{0, 1, 2, 3, 4, 6, 8, 11, 15, 21, 30, 43, 60, 85, 120, 170, 240,
		340, 485, 685, 965, 1365, 2400, 4800, 9600, 19200, 38400, 76800, 153600, 307200, 614400, 614400};
	// rate term in units of 0.005e-6 m/s, by index+16
	localparam logic [20:0] RATE_TBL [32] = '{0, 1, 2, 4, 6, 8, 12, 16, 22, 30, 42, 60, 86, 120, 170, 240, 340,
		480, 680, 970, 1370, 1930, 2730, 4800, 9600, 19200, 38400, 76800, 153600, 307200, 614400, 1228800};
	localparam logic [21:0] CM_TO_ACC_UNITS = 22'h1E8480;
	// text messages
	localparam int POS_TXT_B = 39;
	localparam int W_TXT_B = 236;
	localparam int POS_TXT_A = 128;
	localparam int W_TXT_A = 148;
	localparam logic [4:0] CHARS_B = 5'h1D;
	localparam logic [4:0] CHARS_A = 5'h12;
	localparam int W_CHAR = 8;
	localparam int FIFO_DEPTH = 8;
	// timing
	localparam longint CLK_HZ = 10000000;
	localparam longint OFS_VALID_S = 86400;
	localparam longint OFS_VALID_CYC = OFS_VALID_S * CLK_HZ;
	// ****************************************************************
	// receiver register map (byte offsets), reset word and decoder states
	// ****************************************************************
	localparam logic [7:0] REG_EST_TIME = 8'h00;
	localparam logic [7:0] REG_CUR_WEEK = 8'h04;
	localparam logic [7:0] REG_ELAPSED = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0C;
	localparam logic [7:0] REG_CORR_LO = 8'h10;
	localparam logic [7:0] REG_CORR_HI = 8'h14;
	localparam logic [7:0] REG_FTIME_LO = 8'h18;
	localparam logic [7:0] REG_FTIME_HI = 8'h1C;
	localparam logic [7:0] REG_ACC_LO = 8'h20;
	localparam logic [7:0] REG_ACC_HI = 8'h24;
	localparam logic [7:0] REG_TEXT_CHAR = 8'h28;
	localparam logic [7:0] REG_TEXT_INFO = 8'h2C;
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	typedef enum logic [0:0] {ST_IDLE = 1'b0, ST_TEXT = 1'b1} nmfd_state_t;
endpackage

//--- nmfd_link_if.sv
`timescale 1ns/10ps
interface nmfd_link_if;
	import nmfd_pkg::*;
	logic ofs_stb;
	logic ofs_valid;
	logic [W_SYS-1:0] sys_sel;
	logic sys_no_data;
	logic sys_reserved;
	logic [W_COEF-1:0] bias;
	logic [W_COEF-1:0] drift;
	logic [W_COEF-1:0] drate;
	logic [W_TOW_S-1:0] tow_sec;
	logic [W_WEEK-1:0] ref_week;
	logic [W_CLK-1:0] clk_corr;
	logic dra_stb;
	logic [W_IDX_EXT-1:0] ref_idx;
	logic [W_IDX_EXT-1:0] rate_idx;
	logic ref_unpred;
	logic rate_unpred;
	logic ref_best;
	logic txt_valid;
	logic [W_CHAR-1:0] txt_char;
	logic txt_ready;
	logic txt_stb;
	logic [4:0] txt_len;
	logic txt_kind;
	modport dev (output ofs_stb, ofs_valid, sys_sel, sys_no_data, sys_reserved, bias, drift, drate, tow_sec,
		ref_week, clk_corr, dra_stb, ref_idx, rate_idx, ref_unpred, rate_unpred, ref_best, txt_valid,
		txt_char, txt_stb, txt_len, txt_kind, input txt_ready);
	modport rcv (input ofs_stb, ofs_valid, sys_sel, sys_no_data, sys_reserved, bias, drift, drate, tow_sec,
		ref_week, clk_corr, dra_stb, ref_idx, rate_idx, ref_unpred, rate_unpred, ref_best, txt_valid,
		txt_char, txt_stb, txt_len, txt_kind, output txt_ready);
endinterface

//--- nmfd_fifo.sv
`timescale 1ns/10ps
module nmfd_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0] wr_r;
	logic [AW-1:0] rd_r;
	logic [AW:0] cnt_r;
	logic push;
	logic pop;

	// honest flags from the fill count
	assign in_ready = (cnt_r != (AW+1)'(DEPTH));
	assign out_valid = (cnt_r != '0);
	assign out_data = mem_r[rd_r];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	// storage has no reset; only written entries are ever read
	always_ff @(posedge hclk)
	begin
		if (push)
			mem_r[wr_r] <= in_data;
	end

	// pointers wrap at DEPTH, which need not be a power of two
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_r <= '0;
			rd_r <= '0;
			cnt_r <= '0;
		end
		else
		begin
			if (push)
				wr_r <= (wr_r == AW'(DEPTH-1)) ? '0 : wr_r + 1'b1;
			if (pop)
				rd_r <= (rd_r == AW'(DEPTH-1)) ? '0 : rd_r + 1'b1;
			if (push && !pop)
				cnt_r <= cnt_r + 1'b1;
			else if (pop && !push)
				cnt_r <= cnt_r - 1'b1;
		end
	end
endmodule

//--- nmfd_decoder.sv
`timescale 1ns/10ps
module nmfd_decoder #(
	parameter logic [47:0] VALID_CYCLES = nmfd_pkg::OFS_VALID_CYC[47:0],
	parameter int TXT_DEPTH = nmfd_pkg::FIFO_DEPTH
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic msg_valid,
	input wire logic msg_parity_ok,
	input wire logic [nmfd_pkg::MSG_LEN-1:0] msg_bits,
	output logic msg_ready,
	nmfd_link_if.dev lnk
);
	import nmfd_pkg::*;

	// ****************************************************************
	// message acceptance and field slicing
	// ****************************************************************
	nmfd_state_t state_r;
	logic take;
	logic [W_TYPE-1:0] mtype;
	logic [W_IDX-1:0] ref_f;
	logic [W_IDX-1:0] rate_f;
	logic [W_BIAS-1:0] bias_f;
	logic [W_DRIFT-1:0] drift_f;
	logic [W_DRATE-1:0] drate_f;
	logic [W_SYS-1:0] sys_f;
	logic [47:0] vcnt_r;
	logic [W_TXT_B-1:0] txt_r;
	logic [4:0] left_r;
	logic push;
	logic push_rdy;

	// a message counts only once parity has been accepted upstream
	assign take = msg_valid & msg_ready & msg_parity_ok;
	assign mtype = msg_bits[MSG_LEN-POS_TYPE -: W_TYPE];
	assign sys_f = msg_bits[MSG_LEN-POS_SYS -: W_SYS];
	assign bias_f = msg_bits[MSG_LEN-POS_BIAS -: W_BIAS];
	assign drift_f = msg_bits[MSG_LEN-POS_DRIFT -: W_DRIFT];
	assign drate_f = msg_bits[MSG_LEN-POS_DRATE -: W_DRATE];
	assign ref_f = msg_bits[MSG_LEN-POS_REF_IDX -: W_IDX];
	assign rate_f = msg_bits[MSG_LEN-POS_RATE_IDX -: W_IDX];

	// ****************************************************************
	// time-offset parameter set
	// ****************************************************************
	// coefficients widen by copying the sign bit, never zero fill
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			lnk.sys_sel <= SYS_NONE;
			lnk.sys_no_data <= 1'b1;
			lnk.sys_reserved <= 1'b0;
			lnk.bias <= '0;
			lnk.drift <= '0;
			lnk.drate <= '0;
			lnk.tow_sec <= '0;
			lnk.ref_week <= '0;
			lnk.clk_corr <= '0;
		end
		else if (take && mtype == MT_OFFSET)
		begin
			lnk.sys_sel <= sys_f;
			lnk.sys_no_data <= (sys_f == SYS_NONE);
			lnk.sys_reserved <= (sys_f != SYS_NONE) && (sys_f != SYS_FOREIGN_A) && (sys_f != SYS_FOREIGN_B);
			lnk.bias <= {{(W_COEF-W_BIAS){bias_f[W_BIAS-1]}}, bias_f};
			lnk.drift <= {{(W_COEF-W_DRIFT){drift_f[W_DRIFT-1]}}, drift_f};
			lnk.drate <= {{(W_COEF-W_DRATE){drate_f[W_DRATE-1]}}, drate_f};
			lnk.tow_sec <= {msg_bits[MSG_LEN-POS_TOW -: W_TOW], {TOW_SHIFT{1'b0}}};
			lnk.ref_week <= msg_bits[MSG_LEN-POS_WEEK -: W_WEEK];
			lnk.clk_corr <= msg_bits[MSG_LEN-POS_CLK -: W_CLK];
		end
	end

	// one-cycle strobe per accepted offset message
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			lnk.ofs_stb <= 1'b0;
		else
			lnk.ofs_stb <= take && (mtype == MT_OFFSET);
	end

	// validity window restarts with every fresh set; a "no data" set is never valid
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			vcnt_r <= '0;
			lnk.ofs_valid <= 1'b0;
		end
		else if (take && mtype == MT_OFFSET)
		begin
			vcnt_r <= (sys_f == SYS_NONE) ? '0 : VALID_CYCLES;
			lnk.ofs_valid <= (sys_f != SYS_NONE);
		end
		else if (vcnt_r != '0)
		begin
			vcnt_r <= vcnt_r - 1'b1;
			lnk.ofs_valid <= (vcnt_r != 48'h0000_0000_0001);
		end
	end

	// ****************************************************************
	// differential range accuracy indices
	// ****************************************************************
	// -16 carries no prediction, -15 is the best class
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			lnk.ref_idx <= {3'h7, IDX_UNPRED};
			lnk.rate_idx <= {3'h7, IDX_UNPRED};
			lnk.ref_unpred <= 1'b1;
			lnk.rate_unpred <= 1'b1;
			lnk.ref_best <= 1'b0;
		end
		else if (take && (mtype == MT_DIFF_A || mtype == MT_DIFF_B || mtype == MT_DIFF_C))
		begin
			lnk.ref_idx <= {{(W_IDX_EXT-W_IDX){ref_f[W_IDX-1]}}, ref_f};
			lnk.rate_idx <= {{(W_IDX_EXT-W_IDX){rate_f[W_IDX-1]}}, rate_f};
			lnk.ref_unpred <= (ref_f == IDX_UNPRED);
			lnk.rate_unpred <= (rate_f == IDX_UNPRED);
			lnk.ref_best <= (ref_f == IDX_BEST);
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			lnk.dra_stb <= 1'b0;
		else
			lnk.dra_stb <= take && (mtype == MT_DIFF_A || mtype == MT_DIFF_B || mtype == MT_DIFF_C);
	end

	// ****************************************************************
	// text extraction
	// ****************************************************************
	// new messages wait while a text is still draining into the buffer
	assign push = (state_r == ST_TEXT);

	// characters leave MSB-first from the documented spans only
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			state_r <= ST_IDLE;
			txt_r <= '0;
			left_r <= '0;
			lnk.txt_len <= '0;
			lnk.txt_kind <= 1'b0;
		end
		else
		begin
			unique case (state_r)
				ST_IDLE:
				begin
					if (take && mtype == MT_TEXT_B)
					begin
						txt_r <= msg_bits[MSG_LEN-POS_TXT_B -: W_TXT_B];
						left_r <= CHARS_B;
						lnk.txt_len <= CHARS_B;
						lnk.txt_kind <= 1'b0;
						state_r <= ST_TEXT;
					end
					else if (take && mtype == MT_TEXT_A)
					begin
						txt_r <= {msg_bits[MSG_LEN-POS_TXT_A -: W_TXT_A], {(W_TXT_B-W_TXT_A){1'b0}}};
						left_r <= CHARS_A;
						lnk.txt_len <= CHARS_A;
						lnk.txt_kind <= 1'b1;
						state_r <= ST_TEXT;
					end
				end
				ST_TEXT:
				begin
					if (push_rdy)
					begin
						txt_r <= {txt_r[W_TXT_B-W_CHAR-1:0], {W_CHAR{1'b0}}};
						left_r <= left_r - 1'b1;
						if (left_r == 5'h01)
							state_r <= ST_IDLE;
					end
				end
			endcase
		end
	end

	// end-of-text strobe and the ready seen by the message source
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			lnk.txt_stb <= 1'b0;
			msg_ready <= 1'b1;
		end
		else
		begin
			lnk.txt_stb <= push && push_rdy && (left_r == 5'h01);
			msg_ready <= (state_r == ST_IDLE) ? !(take && (mtype == MT_TEXT_A || mtype == MT_TEXT_B)) :
				(push_rdy && left_r == 5'h01);
		end
	end

	// the buffer absorbs receiver stalls; when full, extraction pauses
	nmfd_fifo #(
		.WIDTH(W_CHAR),
		.DEPTH(TXT_DEPTH)
	) u_txt_fifo (
		.hclk(hclk),
		.hresetn(hresetn),
		.in_valid(push),
		.in_ready(push_rdy),
		.in_data(txt_r[W_TXT_B-1 -: W_CHAR]),
		.out_valid(lnk.txt_valid),
		.out_ready(lnk.txt_ready),
		.out_data(lnk.txt_char)
	);
endmodule

//--- nmfd_receiver.sv
`timescale 1ns/10ps
module nmfd_receiver (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	nmfd_link_if.rcv lnk
);
	import nmfd_pkg::*;

	// ****************************************************************
	// bus slave: zero wait states, always OKAY
	// ****************************************************************
	logic ap;
	logic wr_pend_r;
	logic [7:0] waddr_r;
	logic [19:0] est_time_r;
	logic [W_WEEK-1:0] cur_week_r;
	logic [31:0] elapsed_r;
	logic [63:0] corr_r;
	logic [63:0] ftime_r;
	logic [63:0] acc_r;
	logic hold_v_r;
	logic [W_CHAR-1:0] hold_c_r;
	logic pop;
	logic take_c;
	logic [31:0] status;

	// hsize is not decoded: only whole-word transfers are used
	assign ap = hsel & htrans[1] & hready;
	assign pop = ap & !hwrite & (haddr[7:0] == REG_TEXT_CHAR);
	assign take_c = lnk.txt_valid & lnk.txt_ready;
	assign status = {21'h0, lnk.sys_sel, 3'h0, lnk.rate_unpred, lnk.ref_unpred, lnk.sys_reserved,
		lnk.sys_no_data, lnk.ofs_valid};

	// address phase captured for writes, read data registered at once
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend_r <= 1'b0;
			waddr_r <= '0;
			hrdata <= RST_WORD;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
		else
		begin
			wr_pend_r <= ap & hwrite;
			waddr_r <= haddr[7:0];
			if (ap && !hwrite)
			begin
				unique case (haddr[7:0])
					REG_EST_TIME: hrdata <= {12'h0, est_time_r};
					REG_CUR_WEEK: hrdata <= {19'h0, cur_week_r};
					REG_ELAPSED: hrdata <= elapsed_r;
					REG_STATUS: hrdata <= status;
					REG_CORR_LO: hrdata <= corr_r[31:0];
					REG_CORR_HI: hrdata <= corr_r[63:32];
					REG_FTIME_LO: hrdata <= ftime_r[31:0];
					REG_FTIME_HI: hrdata <= ftime_r[63:32];
					REG_ACC_LO: hrdata <= acc_r[31:0];
					REG_ACC_HI: hrdata <= acc_r[63:32];
					REG_TEXT_CHAR: hrdata <= {23'h0, hold_v_r, hold_c_r};
					REG_TEXT_INFO: hrdata <= {26'h0, lnk.txt_kind, lnk.txt_len};
					default: hrdata <= RST_WORD;
				endcase
			end
		end
	end

	// software inputs to the offset and accuracy arithmetic
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			est_time_r <= '0;
			cur_week_r <= '0;
			elapsed_r <= RST_WORD;
		end
		else if (wr_pend_r)
		begin
			if (waddr_r == REG_EST_TIME)
				est_time_r <= hwdata[19:0];
			if (waddr_r == REG_CUR_WEEK)
				cur_week_r <= hwdata[W_WEEK-1:0];
			if (waddr_r == REG_ELAPSED)
				elapsed_r <= hwdata;
		end
	end

	// ****************************************************************
	// text character holding slot
	// ****************************************************************
	// ready is a flop; a reading of TEXT_CHAR frees the slot
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			hold_v_r <= 1'b0;
			hold_c_r <= '0;
			lnk.txt_ready <= 1'b1;
		end
		else
		begin
			if (take_c)
				hold_c_r <= lnk.txt_char;
			hold_v_r <= take_c | (hold_v_r & !pop);
			lnk.txt_ready <= !(take_c | (hold_v_r & !pop));
		end
	end

	// ****************************************************************
	// foreign time and accuracy arithmetic
	// ****************************************************************
	logic signed [39:0] dt;
	logic signed [13:0] dweek;
	logic signed [63:0] t1;
	logic signed [63:0] t2;
	logic [4:0] rk;
	logic [4:0] vk;

	// dt in seconds includes whole-week rollover; correction in 2^-35 s units
	assign dweek = $signed({1'b0, cur_week_r}) - $signed({1'b0, lnk.ref_week});
	assign dt = 40'($signed({1'b0, est_time_r})) - 40'($signed({1'b0, lnk.tow_sec}))
		+ 40'(dweek * $signed(32'(SEC_PER_WEEK)));
	assign t1 = 64'(($signed(lnk.drift) * dt) >>> 16);
	assign t2 = 64'(($signed(lnk.drate) * dt * dt) >>> 33);
	assign rk = lnk.ref_idx[4:0] ^ IDX_UNPRED;
	assign vk = lnk.rate_idx[4:0] ^ IDX_UNPRED;

	// registered so every readback is a flop; a wrapped product is a user range hazard
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			corr_r <= '0;
			ftime_r <= '0;
			acc_r <= '0;
		end
		else
		begin
			corr_r <= 64'($signed(lnk.bias)) + t1 + t2;
			ftime_r <= {9'h0, est_time_r, 35'h0} - corr_r;
			acc_r <= 64'(REF_CM_TBL[rk]) * 64'(CM_TO_ACC_UNITS) + 64'(RATE_TBL[vk]) * 64'(elapsed_r);
		end
	end
endmodule

//--- nmfd_link_asserts.sv
`timescale 1ns/10ps
// ****************************************************************
// link checker
// ****************************************************************
module nmfd_link_asserts #(
	parameter logic [47:0] VALID_CYCLES = 48'h0000_0000_00C8
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ofs_stb,
	input wire logic ofs_valid,
	input wire logic [nmfd_pkg::W_SYS-1:0] sys_sel,
	input wire logic sys_no_data,
	input wire logic sys_reserved,
	input wire logic [nmfd_pkg::W_COEF-1:0] bias,
	input wire logic [nmfd_pkg::W_COEF-1:0] drift,
	input wire logic [nmfd_pkg::W_COEF-1:0] drate,
	input wire logic [nmfd_pkg::W_TOW_S-1:0] tow_sec,
	input wire logic dra_stb,
	input wire logic [nmfd_pkg::W_IDX_EXT-1:0] ref_idx,
	input wire logic [nmfd_pkg::W_IDX_EXT-1:0] rate_idx,
	input wire logic ref_unpred,
	input wire logic rate_unpred,
	input wire logic ref_best,
	input wire logic txt_valid,
	input wire logic [nmfd_pkg::W_CHAR-1:0] txt_char,
	input wire logic txt_ready,
	input wire logic txt_stb,
	input wire logic [4:0] txt_len,
	input wire logic txt_kind
);
	import nmfd_pkg::*;
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	logic [47:0] age_r;
	// cycles since the last offset strobe; saturates so a long idle cannot wrap
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			age_r <= 48'h0;
		else if (ofs_stb)
			age_r <= 48'h1;
		else if (age_r != 48'hFFFF_FFFF_FFFF)
			age_r <= age_r + 48'h1;
	end
	property p_sel_none; sys_no_data == (sys_sel == SYS_NONE); endproperty
	a_sel_none: assert property (p_sel_none) else $error("no-data flag disagrees with selector");
	property p_sel_resv; sys_reserved == (sys_sel > SYS_FOREIGN_B); endproperty
	a_sel_resv: assert property (p_sel_resv) else $error("reserved flag disagrees with selector");
	property p_valid_sel; ofs_valid |-> sys_sel != SYS_NONE; endproperty
	a_valid_sel: assert property (p_valid_sel) else $error("offset set valid without a system");
	property p_valid_min; $fell(ofs_valid) && !ofs_stb |-> age_r >= VALID_CYCLES - 48'h1; endproperty
	a_valid_min: assert property (p_valid_min) else $error("offset set expired too early");
	property p_valid_max; ofs_valid && !ofs_stb |-> age_r <= VALID_CYCLES + 48'h1; endproperty
	a_valid_max: assert property (p_valid_max) else $error("offset set never expires");
	property p_bias_ext; bias[31:15] == {17{bias[15]}}; endproperty
	a_bias_ext: assert property (p_bias_ext) else $error("bias not sign extended");
	property p_drift_ext; drift[31:12] == {20{drift[12]}}; endproperty
	a_drift_ext: assert property (p_drift_ext) else $error("drift not sign extended");
	property p_drate_ext; drate[31:6] == {26{drate[6]}}; endproperty
	a_drate_ext: assert property (p_drate_ext) else $error("drift rate not sign extended");
	property p_tow_scale; tow_sec[3:0] == 4'h0; endproperty
	a_tow_scale: assert property (p_tow_scale) else $error("reference time not in 16 s steps");
	property p_idx_range; ref_idx[7:4] == {4{ref_idx[4]}} && rate_idx[7:4] == {4{rate_idx[4]}}; endproperty
	a_idx_range: assert property (p_idx_range) else $error("index outside five-bit signed range");
	property p_unpred;
		ref_unpred == (ref_idx == 8'hF0) && rate_unpred == (rate_idx == 8'hF0) && ref_best == (ref_idx == 8'hF1);
	endproperty
	a_unpred: assert property (p_unpred) else $error("index flags disagree with index");
	property p_ofs_hold; $changed(bias) || $changed(sys_sel) |-> ofs_stb; endproperty
	a_ofs_hold: assert property (p_ofs_hold) else $error("offset fields moved without strobe");
	property p_dra_hold; $changed(ref_idx) || $changed(rate_idx) |-> dra_stb; endproperty
	a_dra_hold: assert property (p_dra_hold) else $error("indices moved without strobe");
	property p_txt_len; txt_stb |-> txt_len == (txt_kind ? CHARS_A : CHARS_B); endproperty
	a_txt_len: assert property (p_txt_len) else $error("text length wrong for its kind");
	property p_txt_hold; txt_valid && !txt_ready |=> txt_valid && $stable(txt_char); endproperty
	a_txt_hold: assert property (p_txt_hold) else $error("character dropped while stalled");
	c_foreign_b: cover property (ofs_stb && sys_sel == SYS_FOREIGN_B);
	c_expire: cover property ($fell(ofs_valid));
	c_text_a: cover property (txt_stb && txt_kind);
	c_best: cover property (dra_stb && ref_best);
endmodule

//--- nav_message_field_decoder_bench.sv
`timescale 1ns/10ps
module nav_message_field_decoder_bench;
	import nmfd_pkg::*;
	localparam logic [47:0] VCYC = 48'h0000_0000_00C8;
	logic hclk, hresetn, msg_valid, msg_parity_ok, msg_ready, hsel, hwrite, hreadyout, hresp;
	logic [MSG_LEN-1:0] msg_bits, m;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans;
	logic [2:0] hsize, sl;
	logic [15:0] b;
	logic [5:0] ty [3] = '{MT_DIFF_A, MT_DIFF_B, MT_DIFF_C};
	logic [4:0] rf [3] = '{5'h10, 5'h0F, 5'h11};
	logic [4:0] rt [3] = '{5'h0F, 5'h10, 5'h11};
	int n_errors, checked, cyc, n, p0;
	nmfd_link_if lnk ();
	nmfd_decoder #(.VALID_CYCLES(VCYC), .TXT_DEPTH(FIFO_DEPTH)) nmfd_decoder_i (.hclk(hclk), .hresetn(hresetn),
		.msg_valid(msg_valid), .msg_parity_ok(msg_parity_ok), .msg_bits(msg_bits), .msg_ready(msg_ready), .lnk(lnk));
	nmfd_receiver nmfd_receiver_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .lnk(lnk));
	nmfd_link_asserts #(.VALID_CYCLES(VCYC)) nmfd_link_asserts_i (.hclk(hclk), .hresetn(hresetn),
		.ofs_stb(lnk.ofs_stb), .ofs_valid(lnk.ofs_valid), .sys_sel(lnk.sys_sel), .sys_no_data(lnk.sys_no_data),
		.sys_reserved(lnk.sys_reserved), .bias(lnk.bias), .drift(lnk.drift), .drate(lnk.drate),
		.tow_sec(lnk.tow_sec), .dra_stb(lnk.dra_stb), .ref_idx(lnk.ref_idx), .rate_idx(lnk.rate_idx),
		.ref_unpred(lnk.ref_unpred), .rate_unpred(lnk.rate_unpred), .ref_best(lnk.ref_best),
		.txt_valid(lnk.txt_valid), .txt_char(lnk.txt_char), .txt_ready(lnk.txt_ready), .txt_stb(lnk.txt_stb),
		.txt_len(lnk.txt_len), .txt_kind(lnk.txt_kind));
	// ****************************************************************
	// clock, watchdog and shared tasks
	// ****************************************************************
	initial hclk = 1'b0;
	always #50 hclk = ~hclk;
	// a hung handshake would otherwise stall the run forever
	always @(posedge hclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			n_errors++;
			$display("watchdog expired");
			end_of_test();
		end
	end
	task automatic end_of_test;
		$display("mismatches %0d comparisons %0d", n_errors, checked);
		if (n_errors == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// one single-word transfer; zero-wait is not assumed, hready is polled
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= wr;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
		chk("hresp", 32'(hresp), 32'h0);
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
		ahb(1'b0, a, 32'h0);
		chk(what, rd, exp);
	endtask
	function automatic void put(input int p, input int w, input logic [31:0] v);
		for (int i = 0; i < w; i++)
			m[MSG_LEN-p-i] = v[w-1-i];
	endfunction
	// unused bits are ones so a misplaced field shows up
	function automatic void newmsg(input logic [5:0] t);
		m = '1;
		put(POS_TYPE, W_TYPE, 32'(t));
	endfunction
	// offer m until taken, then settle in the cycle that carries the strobe
	task automatic send(input logic ok);
		@(posedge hclk);
		msg_valid <= 1'b1;
		msg_parity_ok <= ok;
		msg_bits <= m;
		do @(posedge hclk); while (msg_ready !== 1'b1);
		msg_valid <= 1'b0;
		@(negedge hclk);
	endtask
	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial
	begin
		{hresetn, msg_valid, msg_parity_ok, hsel, hwrite, htrans} = '0;
		{msg_bits, haddr, hwdata, n_errors, checked, cyc} = '0;
		hsize = 3'h2;
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		rdchk(REG_STATUS, 32'h0000_001A, "status at reset");
		rdchk(8'h40, 32'h0, "unmapped");
		// every selector code, both signs of each coefficient
		for (int s = 0; s < 8; s++)
		begin
			sl = s[2:0];
			b = sl[0] ? 16'h8001 : 16'h7FFE;
			newmsg(MT_OFFSET);
			put(POS_CLK, 1, 32'h0);
			put(POS_SYS, W_SYS, 32'(sl));
			put(POS_TOW, W_TOW, 32'hFFFF);
			put(POS_WEEK, W_WEEK, 32'h1ABC);
			put(POS_BIAS, W_BIAS, 32'(b));
			put(POS_DRIFT, W_DRIFT, {19'h0, sl[1], 12'h001});
			put(POS_DRATE, W_DRATE, {25'h0, sl[2], 6'h01});
			send(1'b1);
			chk("ofs_stb", 32'(lnk.ofs_stb), 32'h1);
			chk("sys_sel", 32'(lnk.sys_sel), 32'(sl));
			chk("clk_corr", 32'(lnk.clk_corr === {1'b0, {88{1'b1}}}), 32'h1);
			chk("bias", lnk.bias, {{16{b[15]}}, b});
			chk("drift", lnk.drift, {{19{sl[1]}}, sl[1], 12'h001});
			chk("drate", lnk.drate, {{25{sl[2]}}, sl[2], 6'h01});
			chk("tow_sec", 32'(lnk.tow_sec), 32'h000F_FFF0);
			chk("ref_week", 32'(lnk.ref_week), 32'h1ABC);
			rdchk(REG_STATUS, {21'h0, sl, 3'h0, 2'b11, sl > 3'h2, sl == 3'h0, sl != 3'h0}, "status");
		end
		// a message failing parity leaves the fields alone
		put(POS_SYS, W_SYS, 32'h2);
		send(1'b0);
		chk("parity drop", 32'(lnk.sys_sel), 32'h7);
		// dt of 2^17 s makes drift and drift-rate terms exact
		newmsg(MT_OFFSET);
		put(POS_SYS, W_SYS, 32'h1);
		put(POS_TOW, W_TOW, 32'h1);
		put(POS_WEEK, W_WEEK, 32'h5);
		put(POS_BIAS, W_BIAS, 32'h8001);
		send(1'b1);
		ahb(1'b1, REG_EST_TIME, 32'h20010);
		ahb(1'b1, REG_CUR_WEEK, 32'h5);
		repeat (3) @(posedge hclk);
		rdchk(REG_EST_TIME, 32'h20010, "est time");
		rdchk(REG_CORR_LO, 32'hFFFF_7FFD, "corr lo");
		rdchk(REG_CORR_HI, 32'hFFFF_FFFF, "corr hi");
		rdchk(REG_FTIME_LO, 32'h0000_8003, "ftime lo");
		rdchk(REG_FTIME_HI, 32'h0010_0080, "ftime hi");
		chk("valid held", 32'(lnk.ofs_valid), 32'h1);
		repeat (200) @(negedge hclk);
		chk("valid expired", 32'(lnk.ofs_valid), 32'h0);
		// accuracy indices through each carrier type, boundary values
		for (int i = 0; i < 3; i++)
		begin
			newmsg(ty[i]);
			put(POS_REF_IDX, W_IDX, 32'(rf[i]));
			put(POS_RATE_IDX, W_IDX, 32'(rt[i]));
			send(1'b1);
			chk("dra_stb", 32'(lnk.dra_stb), 32'h1);
			chk("ref_idx", 32'(lnk.ref_idx), {24'h0, {3{rf[i][4]}}, rf[i]});
			chk("rate_idx", 32'(lnk.rate_idx), {24'h0, {3{rt[i][4]}}, rt[i]});
			chk("ref_unpred", 32'(lnk.ref_unpred), 32'(rf[i] == 5'h10));
			chk("rate_unpred", 32'(lnk.rate_unpred), 32'(rt[i] == 5'h10));
			chk("ref_best", 32'(lnk.ref_best), 32'(rf[i] == 5'h11));
		end
		// best index: 1 cm reference plus one rate unit per elapsed second
		ahb(1'b1, REG_ELAPSED, 32'hA);
		repeat (3) @(posedge hclk);
		rdchk(REG_ACC_LO, 32'h001E_848A, "acc lo");
		rdchk(REG_ACC_HI, 32'h0, "acc hi");
		// both text kinds; a lagging reader fills the buffer
		for (int k = 0; k < 2; k++)
		begin
			n = k ? 18 : 29;
			p0 = k ? POS_TXT_A : POS_TXT_B;
			newmsg(k ? MT_TEXT_A : MT_TEXT_B);
			for (int i = 0; i < n; i++)
				put(p0 + 8 * i, W_CHAR, 32'h41 + 32'(i));
			send(1'b1);
			chk("busy", 32'(msg_ready), 32'h0);
			repeat (30) @(posedge hclk);
			chk("busy stalled", 32'(msg_ready), 32'h0);
			for (int i = 0; i < n; i++)
			begin
				do ahb(1'b0, REG_TEXT_CHAR, 32'h0); while (rd[8] !== 1'b1);
				chk("char", rd, 32'h141 + 32'(i));
			end
			repeat (5) @(posedge hclk);
			ahb(1'b0, REG_TEXT_CHAR, 32'h0);
			chk("no extra char", 32'(rd[8]), 32'h0);
			rdchk(REG_TEXT_INFO, 32'(k * 32 + n), "text info");
			chk("ready again", 32'(msg_ready), 32'h1);
		end
		end_of_test();
	end
endmodule
